// [bench/utm_entry_store.sv]
// mapped-entry store model on the far side of the copy sequencer
// assumes each request is held until its acknowledge is seen
`timescale 1ns/1ps
module utm_entry_store (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sequencer request and answer
    input wire logic xReq,
    input wire logic xWrite,
    input wire utm_pkg::utm_desc_type xDesc,
    input wire logic [31:0] xWdata,
    output logic xAck,
    output logic [31:0] xRdata,
    // bench control and store log
    input wire logic [2:0] lag,
    output logic [63:0] storeLog,
    output logic [7:0] storeCount
);
    logic [2:0] waitCnt;
    // ----------------------------------------------------------------
    // answer after lag cycles; read data toggles outside the answer so
    // a late sample never looks plausible
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        xRdata <= ~xRdata;
        xAck <= 1'b0;
        if (!rst_n) begin
            xRdata <= 32'h0;
            waitCnt <= 3'h0;
            storeLog <= 64'h0;
            storeCount <= 8'h0;
        end else if (xReq && !xAck && waitCnt >= lag) begin
            xAck <= 1'b1;
            waitCnt <= 3'h0;
            xRdata <= {8'hc3, xDesc.subIndex, xDesc.index};
            if (xWrite) begin
                storeLog <= {storeLog[31:0], xWdata};
                storeCount <= storeCount + 8'h1;
            end
        end else if (xReq && !xAck) begin
            waitCnt <= waitCnt + 3'h1;
        end
    end
endmodule // utm_entry_store

// [bench/utm_uptime_maps_sva.sv]
// assertions on dictionary answers, counters and the copy handshake
// assumes it is bound into utm_uptime_maps and sees only its ports
`timescale 1ns/1ps
module utm_uptime_maps_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // dictionary side
    input wire logic odReq,
    input wire utm_pkg::utm_od_req_type odCmd,
    input wire logic odAck,
    input wire logic odAbort,
    input wire logic [31:0] odRdata,
    input wire logic [31:0] txSeconds,
    // sequencer side
    input wire logic preRun,
    input wire logic postRun,
    input wire logic busy,
    input wire logic preDone,
    input wire logic postDone,
    input wire logic xReq,
    input wire utm_pkg::utm_desc_type xDesc,
    input wire logic xAck
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    AST_ACK_NEXT: assert property (odReq |=> odAck)
        else $error("no answer after request");
    AST_RO_WRITE: assert property (
        odReq && odCmd.write && odCmd.index
        inside {16'h230e, 16'h230f, 16'h2310, 16'h2320, 16'h2330}
        |=> odAbort && odRdata == 32'h0)
        else $error("write to read-only entry accepted");
    AST_COUNT: assert property (
        odReq && !odCmd.write && odCmd.subIndex == 0
        && odCmd.index inside {16'h2310, 16'h2320, 16'h2330}
        |=> !odAbort && odRdata == 32'h10)
        else $error("table count slot wrong");
    AST_SEC_STEP: assert property (!$stable(txSeconds)
        |-> txSeconds == $past(txSeconds) + 32'h1)
        else $error("seconds moved by other than one");
    AST_START_ZERO: assert property ($rose(rst_n)
        |-> txSeconds == 32'h0 && !busy && !odAck)
        else $error("state not cleared by reset");
    AST_XREQ_HOLD: assert property (xReq && !xAck
        |=> xReq && $stable(xDesc))
        else $error("entry request dropped early");
    AST_BUSY_START: assert property ((preRun || postRun) && !busy
        |=> busy)
        else $error("copy did not start");
    AST_DONE_END: assert property (preDone || postDone
        |-> !busy && $past(busy))
        else $error("done strobe outside a copy");
    // main scenarios reached
    CV_ABORT: cover property (odAck && odAbort);
    CV_PRE: cover property (preDone);
    CV_POST: cover property (postDone);
endmodule // utm_uptime_maps_sva

bind utm_uptime_maps utm_uptime_maps_sva chk (.clk(clk), .rst_n(rst_n),
    .odReq(odReq), .odCmd(odCmd), .odAck(odAck), .odAbort(odAbort),
    .odRdata(odRdata), .txSeconds(txSeconds), .preRun(preRun),
    .postRun(postRun), .busy(busy), .preDone(preDone),
    .postDone(postDone), .xReq(xReq), .xDesc(xDesc), .xAck(xAck));

// [bench/utm_uptime_maps_tb.sv]
// bench: dictionary accesses, descriptor loads, copy runs, counters
// assumes the entry store model and the bound checker in bench/
`timescale 1ns/1ps
module utm_uptime_maps_tb;
    localparam int MS_SHORT = 20;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic odReq = 1'b0;
    utm_pkg::utm_od_req_type odCmd = '0;
    logic mapLoad = 1'b0;
    logic [1:0] mapTable = 2'h0;
    logic [3:0] mapSlot = 4'h0;
    utm_pkg::utm_desc_type mapWord = '0;
    logic preRun = 1'b0;
    logic postRun = 1'b0;
    logic outWr = 1'b0;
    logic [4:0] imgSel = 5'h0;
    logic [4:0] outSel = 5'h0;
    logic [4:0] mbxSel = 5'h0;
    logic [31:0] outData = 32'h0;
    logic [2:0] lag = 3'h0;
    logic odAck, odAbort, busy, preDone, postDone, xReq, xWrite, xAck;
    logic [31:0] odRdata, txSeconds, imgData, mbxData, xWdata, xRdata;
    utm_pkg::utm_desc_type xDesc;
    logic [63:0] storeLog;
    logic [7:0] storeCount;
    logic [31:0] rdVal, msVal;
    logic abortVal;
    logic [15:0] tbls [3] = '{16'h2310, 16'h2320, 16'h2330};
    int failCount = 0;
    int checksDone = 0;

    always #25 clk = ~clk;

    utm_uptime_maps #(.MS_CYCLES(MS_SHORT)) dut (.clk(clk), .rst_n(rst_n),
        .odReq(odReq), .odCmd(odCmd), .odAck(odAck), .odAbort(odAbort),
        .odRdata(odRdata), .txSeconds(txSeconds), .mapLoad(mapLoad),
        .mapTable(mapTable), .mapSlot(mapSlot), .mapWord(mapWord),
        .preRun(preRun), .postRun(postRun), .busy(busy),
        .preDone(preDone), .postDone(postDone), .imgSel(imgSel),
        .imgData(imgData), .outWr(outWr), .outSel(outSel),
        .outData(outData), .mbxSel(mbxSel), .mbxData(mbxData),
        .xReq(xReq), .xWrite(xWrite), .xDesc(xDesc), .xWdata(xWdata),
        .xAck(xAck), .xRdata(xRdata));
    utm_entry_store store (.clk(clk), .rst_n(rst_n), .xReq(xReq),
        .xWrite(xWrite), .xDesc(xDesc), .xWdata(xWdata), .xAck(xAck),
        .xRdata(xRdata), .lag(lag), .storeLog(storeLog),
        .storeCount(storeCount));

    // ----------------------------------------------------------------
    // access tasks; every task starts and ends just after a rising edge
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // request stays high across back-to-back calls; caller drops it
    task automatic od(input logic wr, input logic [15:0] idx,
                      input logic [7:0] sub, input logic [31:0] wd);
        odReq = 1'b1;
        odCmd = '{wr, idx, sub, wd};
        step();
        chk("answer", 32'h1, {31'h0, odAck});
        rdVal = odRdata;
        abortVal = odAbort;
    endtask
    task automatic acc(input logic wr, input logic [15:0] idx,
        input logic [7:0] sub, input logic [31:0] wd, input logic [31:0] e);
        od(wr, idx, sub, wd);
        chk("read data", e, rdVal);
        chk("refusal", 32'h0, {31'h0, abortVal});
    endtask
    task automatic bad(input logic wr, input logic [15:0] idx,
                       input logic [7:0] sub);
        od(wr, idx, sub, 32'h5a5a5a5a);
        chk("refusal", 32'h1, {31'h0, abortVal});
    endtask
    task automatic load(input logic [1:0] t, input logic [3:0] s,
                        input logic [31:0] w);
        mapLoad = 1'b1;
        mapTable = t;
        mapSlot = s;
        mapWord = w;
        step();
    endtask
    // start a copy and wait a bounded time for its done strobe
    task automatic run(input logic post);
        int n;
        n = 0;
        // both starts together on a pre run: the input copy wins
        preRun = !post;
        postRun = 1'b1;
        step();
        // a start while busy must be ignored
        preRun = post;
        step();
        preRun = 1'b0;
        postRun = 1'b0;
        while (!(preDone || postDone) && n < 500) begin
            step();
            n++;
        end
        chk("done strobes", post ? 32'h2 : 32'h1, {30'h0, postDone, preDone});
        step();
        chk("idle after copy", 32'h0, {31'h0, busy});
    endtask
    task automatic img(input logic [4:0] s, input logic [31:0] e);
        imgSel = s;
        step();
        chk("image word", e, imgData);
    endtask
    task automatic wrapUp();
        if (failCount == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) step();
        rst_n = 1'b1;
        step();
        acc(1'b0, 16'h230e, 8'h00, 32'h0, 32'h1);
        acc(1'b0, 16'h230f, 8'h00, 32'h0, 32'h0);
        acc(1'b0, 16'h2400, 8'h00, 32'h0, 32'h20);
        foreach (tbls[i]) begin
            acc(1'b0, tbls[i], 8'h00, 32'h0, 32'h10);
            acc(1'b0, tbls[i], 8'h10, 32'h0, 32'h0);
            bad(1'b1, tbls[i], 8'h01);
            bad(1'b0, tbls[i], 8'h11);
        end
        bad(1'b1, 16'h230f, 8'h00);
        bad(1'b1, 16'h230e, 8'h01);
        bad(1'b0, 16'h230e, 8'h02);
        bad(1'b0, 16'h230f, 8'h01);
        bad(1'b0, 16'h2400, 8'h21);
        bad(1'b1, 16'h2400, 8'h00);
        acc(1'b1, 16'h2400, 8'h01, 32'h80000001, 32'h0);
        acc(1'b1, 16'h2400, 8'h20, 32'h7ffffffe, 32'h0);
        acc(1'b0, 16'h2400, 8'h01, 32'h0, 32'h80000001);
        odReq = 1'b0;
        mbxSel = 5'h1f;
        step();
        chk("mailbox port", 32'h7ffffffe, mbxData);
        load(2'h0, 4'h0, 32'h24000110);
        load(2'h1, 4'h3, 32'h24020308);
        load(2'h2, 4'hf, 32'h24010220);
        load(2'h3, 4'h1, 32'h11111111);
        mapLoad = 1'b0;
        acc(1'b0, 16'h2310, 8'h01, 32'h0, 32'h24000110);
        acc(1'b0, 16'h2320, 8'h04, 32'h0, 32'h24020308);
        acc(1'b0, 16'h2330, 8'h10, 32'h0, 32'h24010220);
        foreach (tbls[i]) begin
            acc(1'b0, tbls[i], 8'h02, 32'h0, 32'h0);
        end
        odReq = 1'b0;
        run(1'b0);
        img(5'h00, 32'h00002400);
        img(5'h01, 32'h0);
        img(5'h1f, 32'hc3022401);
        lag = 3'h3;
        outWr = 1'b1;
        outSel = 5'h03;
        outData = 32'h12345678;
        step();
        outSel = 5'h1f;
        outData = 32'h9abcdef0;
        step();
        outWr = 1'b0;
        run(1'b1);
        chk("store count", 32'h2, {24'h0, storeCount});
        chk("first store", 32'h00000078, storeLog[63:32]);
        chk("second store", 32'h9abcdef0, storeLog[31:0]);
        repeat (MS_SHORT * 1000) step();
        od(1'b0, 16'h230e, 8'h01, 32'h0);
        msVal = rdVal;
        od(1'b0, 16'h230f, 8'h00, 32'h0);
        odReq = 1'b0;
        chk("seconds vs ms", msVal / 1000, rdVal);
        chk("ms range", 32'h1, {31'h0, msVal>999 && msVal<1030});
        chk("seconds out", 32'h1, txSeconds);
        rst_n = 1'b0;
        repeat (2) step();
        rst_n = 1'b1;
        step();
        chk("seconds restart", 32'h0, txSeconds);
        acc(1'b0, 16'h2310, 8'h01, 32'h0, 32'h0);
        odReq = 1'b0;
        wrapUp();
    end

    // cut a hang short well beyond the expected run length
    initial begin
        #(30000 * 50);
        failCount++;
        wrapUp();
    end
endmodule // utm_uptime_maps_tb

// [core/utm_pkg.sv]
// constants and types shared by the uptime counters and mapping tables
// assumes a single 20 MHz clock and a synchronous active-low reset
package utm_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int MS_CYCLES = (MS_PERIOD_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam logic [9:0] MS_PER_SECOND = 10'h3e8;

    // ------------------------------------------------------------------
    // dictionary indices
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_MS_TIMER = 16'h230e;
    localparam logic [15:0] IDX_SECONDS = 16'h230f;
    localparam logic [15:0] IDX_IN_MAP = 16'h2310;
    localparam logic [15:0] IDX_OUT_MAP = 16'h2320;
    localparam logic [15:0] IDX_INOUT_MAP = 16'h2330;
    localparam logic [15:0] IDX_MAILBOX = 16'h2400;

    // ------------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] MS_TIMER_COUNT = 32'h00000001;
    localparam logic [31:0] MAP_COUNT = 32'h00000010;
    localparam logic [31:0] MAILBOX_COUNT = 32'h00000020;
    localparam logic [31:0] COUNTER_RESET = 32'h00000000;
    localparam logic [31:0] DESC_RESET = 32'h00000000;
    localparam logic [31:0] MAILBOX_RESET = 32'h00000000;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_FIRST = 8'h01;

    // table selectors on the program load port
    localparam logic [1:0] TBL_IN = 2'h0;
    localparam logic [1:0] TBL_OUT = 2'h1;
    localparam logic [1:0] TBL_INOUT = 2'h2;

    // one mapping descriptor: index 31..16, subindex 15..8, bits 7..0
    typedef struct packed {
        logic [15:0] index;
        logic [7:0] subIndex;
        logic [7:0] lengthBits;
    } utm_desc_type;

    // a dictionary access as it arrives from the fieldbus side
    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [7:0] subIndex;
        logic [31:0] data;
    } utm_od_req_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SCAN,
        ST_WAIT
    } utm_state_type;

endpackage

// [core/utm_uptime_maps.sv]
// uptime counters, program mapping tables, mailbox and copy sequencer
// assumes the dictionary requester and the entry store answer on clk
//
// Contract
// - read-only 32-bit seconds counter, reset zero
// - seconds restart at reset, wrap on overflow
// - seconds on cyclic output; writes refused
// - read-only millisecond counter, restarts, wraps
// - sixteen descriptors per table, count reads sixteen
// - descriptor: index, subindex, length fields
// - length field counts bits, not bytes
// - input table copied into image before run
// - output table copied out after run
// - inout table copied in, then back
// - tables read-only to bus, zero, volatile
// - thirty-two word mailbox, uninterpreted
`timescale 1ns/1ps
module utm_uptime_maps #(
    parameter int MS_CYCLES = utm_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // dictionary access from the fieldbus side
    input wire logic odReq,
    input wire utm_pkg::utm_od_req_type odCmd,
    output logic odAck,
    output logic odAbort,
    output logic [31:0] odRdata,
    // cyclic transmit process data
    output logic [31:0] txSeconds,
    // descriptor load from the program loader
    input wire logic mapLoad,
    input wire logic [1:0] mapTable,
    input wire logic [3:0] mapSlot,
    input wire utm_pkg::utm_desc_type mapWord,
    // user program side
    input wire logic preRun,
    input wire logic postRun,
    output logic busy,
    output logic preDone,
    output logic postDone,
    input wire logic [4:0] imgSel,
    output logic [31:0] imgData,
    input wire logic outWr,
    input wire logic [4:0] outSel,
    input wire logic [31:0] outData,
    input wire logic [4:0] mbxSel,
    output logic [31:0] mbxData,
    // access to the mapped dictionary entries
    output logic xReq,
    output logic xWrite,
    output utm_pkg::utm_desc_type xDesc,
    output logic [31:0] xWdata,
    input wire logic xAck,
    input wire logic [31:0] xRdata
);

    // ------------------------------------------------------------------
    // uptime counters
    // ------------------------------------------------------------------
    logic [31:0] preCnt_r, preCnt_nxt;
    logic [9:0] msInSec_r, msInSec_nxt;
    logic [31:0] msCount_r, msCount_nxt;
    logic [31:0] secCount_r, secCount_nxt;

    // one prescaler feeds both counts so they never drift apart
    always_comb begin
        preCnt_nxt = preCnt_r + 32'h00000001;
        msInSec_nxt = msInSec_r;
        msCount_nxt = msCount_r;
        secCount_nxt = secCount_r;
        if (preCnt_r == 32'(MS_CYCLES - 1)) begin
            preCnt_nxt = 32'h00000000;
            msCount_nxt = msCount_r + 32'h00000001;
            msInSec_nxt = msInSec_r + 10'h001;
            if (msInSec_r == utm_pkg::MS_PER_SECOND - 10'h001) begin
                msInSec_nxt = 10'h000;
                secCount_nxt = secCount_r + 32'h00000001;
            end
        end
    end

    // counters are volatile: reset is the only start point
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preCnt_r <= 32'h00000000;
            msInSec_r <= 10'h000;
            msCount_r <= utm_pkg::COUNTER_RESET;
            secCount_r <= utm_pkg::COUNTER_RESET;
        end else begin
            preCnt_r <= preCnt_nxt;
            msInSec_r <= msInSec_nxt;
            msCount_r <= msCount_nxt;
            secCount_r <= secCount_nxt;
        end
    end

    assign txSeconds = secCount_r;

    // ------------------------------------------------------------------
    // tables, images, mailbox and dictionary answers
    // ------------------------------------------------------------------
    utm_pkg::utm_desc_type inTbl_r [16], inTbl_nxt [16];
    utm_pkg::utm_desc_type outTbl_r [16], outTbl_nxt [16];
    utm_pkg::utm_desc_type ioTbl_r [16], ioTbl_nxt [16];
    logic [31:0] mbx_r [32], mbx_nxt [32];
    logic [31:0] inImg_r [32], inImg_nxt [32];
    logic [31:0] outImg_r [32], outImg_nxt [32];
    logic ack_r, ack_nxt, abort_r, abort_nxt;
    logic [31:0] rdata_r, rdata_nxt, imgData_r, imgData_nxt;
    logic [31:0] mbxData_r, mbxData_nxt;
    logic subTbl, subMbx;
    logic [3:0] tblIdx;
    logic [4:0] mbxIdx;

    // copy sequencer state, declared here since images depend on it
    utm_pkg::utm_state_type st_r, st_nxt;
    logic post_r, post_nxt;
    logic [4:0] slot_r, slot_nxt;
    logic [31:0] mask_r, mask_nxt;
    logic xReq_r, xReq_nxt;

    assign subTbl = odCmd.subIndex >= utm_pkg::SUB_FIRST &&
                    odCmd.subIndex <= utm_pkg::MAP_COUNT[7:0];
    assign subMbx = odCmd.subIndex >= utm_pkg::SUB_FIRST &&
                    odCmd.subIndex <= utm_pkg::MAILBOX_COUNT[7:0];
    assign tblIdx = 4'(odCmd.subIndex - utm_pkg::SUB_FIRST);
    assign mbxIdx = 5'(odCmd.subIndex - utm_pkg::SUB_FIRST);

    // decode one access per cycle; answer follows one cycle later
    always_comb begin
        inTbl_nxt = inTbl_r;
        outTbl_nxt = outTbl_r;
        ioTbl_nxt = ioTbl_r;
        mbx_nxt = mbx_r;
        inImg_nxt = inImg_r;
        outImg_nxt = outImg_r;
        ack_nxt = odReq;
        abort_nxt = 1'b0;
        rdata_nxt = 32'h00000000;
        imgData_nxt = inImg_r[imgSel];
        mbxData_nxt = mbx_r[mbxSel];
        if (odReq) begin
            abort_nxt = 1'b1;
            unique case (odCmd.index)
                utm_pkg::IDX_MS_TIMER: begin
                    if (!odCmd.write &&
                        odCmd.subIndex == utm_pkg::SUB_COUNT) begin
                        abort_nxt = 1'b0;
                        rdata_nxt = utm_pkg::MS_TIMER_COUNT;
                    end else if (!odCmd.write &&
                                 odCmd.subIndex == utm_pkg::SUB_FIRST) begin
                        abort_nxt = 1'b0;
                        rdata_nxt = msCount_r;
                    end
                end
                utm_pkg::IDX_SECONDS: begin
                    // plain variable: subindex 0 only, writes refused
                    if (!odCmd.write &&
                        odCmd.subIndex == utm_pkg::SUB_COUNT) begin
                        abort_nxt = 1'b0;
                        rdata_nxt = secCount_r;
                    end
                end
                utm_pkg::IDX_IN_MAP, utm_pkg::IDX_OUT_MAP,
                utm_pkg::IDX_INOUT_MAP: begin
                    if (!odCmd.write &&
                        odCmd.subIndex == utm_pkg::SUB_COUNT) begin
                        abort_nxt = 1'b0;
                        rdata_nxt = utm_pkg::MAP_COUNT;
                    end else if (!odCmd.write && subTbl) begin
                        abort_nxt = 1'b0;
                        if (odCmd.index == utm_pkg::IDX_IN_MAP)
                            rdata_nxt = inTbl_r[tblIdx];
                        else if (odCmd.index == utm_pkg::IDX_OUT_MAP)
                            rdata_nxt = outTbl_r[tblIdx];
                        else
                            rdata_nxt = ioTbl_r[tblIdx];
                    end
                end
                utm_pkg::IDX_MAILBOX: begin
                    if (!odCmd.write &&
                        odCmd.subIndex == utm_pkg::SUB_COUNT) begin
                        abort_nxt = 1'b0;
                        rdata_nxt = utm_pkg::MAILBOX_COUNT;
                    end else if (subMbx) begin
                        abort_nxt = 1'b0;
                        if (odCmd.write)
                            mbx_nxt[mbxIdx] = odCmd.data;
                        else
                            rdata_nxt = mbx_r[mbxIdx];
                    end
                end
                default: abort_nxt = 1'b1;
            endcase
        end
        // descriptors come only from the program loader, never the bus
        if (mapLoad) begin
            unique case (mapTable)
                utm_pkg::TBL_IN: inTbl_nxt[mapSlot] = mapWord;
                utm_pkg::TBL_OUT: outTbl_nxt[mapSlot] = mapWord;
                utm_pkg::TBL_INOUT: ioTbl_nxt[mapSlot] = mapWord;
                default: ;
            endcase
        end
        if (outWr)
            outImg_nxt[outSel] = outData;
        // fetched value lands in the input image, trimmed to its bits
        if (st_r == utm_pkg::ST_WAIT && xAck && !post_r)
            inImg_nxt[slot_r] = xRdata & mask_r;
    end

    // no retention: all table and image contents restart at zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                inTbl_r[i] <= utm_pkg::DESC_RESET;
                outTbl_r[i] <= utm_pkg::DESC_RESET;
                ioTbl_r[i] <= utm_pkg::DESC_RESET;
            end
            for (int i = 0; i < 32; i++) begin
                mbx_r[i] <= utm_pkg::MAILBOX_RESET;
                inImg_r[i] <= 32'h00000000;
                outImg_r[i] <= 32'h00000000;
            end
            ack_r <= 1'b0;
            abort_r <= 1'b0;
            rdata_r <= 32'h00000000;
            imgData_r <= 32'h00000000;
            mbxData_r <= 32'h00000000;
        end else begin
            inTbl_r <= inTbl_nxt;
            outTbl_r <= outTbl_nxt;
            ioTbl_r <= ioTbl_nxt;
            mbx_r <= mbx_nxt;
            inImg_r <= inImg_nxt;
            outImg_r <= outImg_nxt;
            ack_r <= ack_nxt;
            abort_r <= abort_nxt;
            rdata_r <= rdata_nxt;
            imgData_r <= imgData_nxt;
            mbxData_r <= mbxData_nxt;
        end
    end

    assign odAck = ack_r;
    assign odAbort = abort_r;
    assign odRdata = rdata_r;
    assign imgData = imgData_r;
    assign mbxData = mbxData_r;

    // ------------------------------------------------------------------
    // copy sequencer
    // ------------------------------------------------------------------
    utm_pkg::utm_desc_type curDesc, xDesc_r, xDesc_nxt;
    logic [31:0] curMask, xWdata_r, xWdata_nxt;
    logic preDone_r, preDone_nxt, postDone_r, postDone_nxt;
    logic lastSlot;

    // slots 0..15 walk the in or out table, 16..31 the inout table
    always_comb begin
        if (slot_r[4])
            curDesc = ioTbl_r[slot_r[3:0]];
        else if (post_r)
            curDesc = outTbl_r[slot_r[3:0]];
        else
            curDesc = inTbl_r[slot_r[3:0]];
        // lengths of 32 or more pass the whole word
        if (curDesc.lengthBits >= 8'h20)
            curMask = 32'hffffffff;
        else
            curMask = (32'h00000001 << curDesc.lengthBits) - 32'h00000001;
    end

    assign lastSlot = slot_r == 5'h1f;

    // empty descriptors are skipped so unmapped slots cost one cycle
    always_comb begin
        st_nxt = st_r;
        post_nxt = post_r;
        slot_nxt = slot_r;
        mask_nxt = mask_r;
        xReq_nxt = xReq_r;
        xDesc_nxt = xDesc_r;
        xWdata_nxt = xWdata_r;
        preDone_nxt = 1'b0;
        postDone_nxt = 1'b0;
        unique case (st_r)
            utm_pkg::ST_IDLE: begin
                if (preRun || postRun) begin
                    st_nxt = utm_pkg::ST_SCAN;
                    post_nxt = !preRun;
                    slot_nxt = 5'h00;
                end
            end
            utm_pkg::ST_SCAN: begin
                if (curDesc != utm_pkg::DESC_RESET) begin
                    st_nxt = utm_pkg::ST_WAIT;
                    xReq_nxt = 1'b1;
                    xDesc_nxt = curDesc;
                    mask_nxt = curMask;
                    xWdata_nxt = outImg_r[slot_r] & curMask;
                end else if (lastSlot) begin
                    st_nxt = utm_pkg::ST_IDLE;
                    preDone_nxt = !post_r;
                    postDone_nxt = post_r;
                end else begin
                    slot_nxt = slot_r + 5'h01;
                end
            end
            utm_pkg::ST_WAIT: begin
                if (xAck) begin
                    xReq_nxt = 1'b0;
                    if (lastSlot) begin
                        st_nxt = utm_pkg::ST_IDLE;
                        preDone_nxt = !post_r;
                        postDone_nxt = post_r;
                    end else begin
                        st_nxt = utm_pkg::ST_SCAN;
                        slot_nxt = slot_r + 5'h01;
                    end
                end
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= utm_pkg::ST_IDLE;
            post_r <= 1'b0;
            slot_r <= 5'h00;
            mask_r <= 32'h00000000;
            xReq_r <= 1'b0;
            xDesc_r <= utm_pkg::DESC_RESET;
            xWdata_r <= 32'h00000000;
            preDone_r <= 1'b0;
            postDone_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            post_r <= post_nxt;
            slot_r <= slot_nxt;
            mask_r <= mask_nxt;
            xReq_r <= xReq_nxt;
            xDesc_r <= xDesc_nxt;
            xWdata_r <= xWdata_nxt;
            preDone_r <= preDone_nxt;
            postDone_r <= postDone_nxt;
        end
    end

    assign busy = st_r != utm_pkg::ST_IDLE;
    assign xReq = xReq_r;
    assign xWrite = post_r;
    assign xDesc = xDesc_r;
    assign xWdata = xWdata_r;
    assign preDone = preDone_r;
    assign postDone = postDone_r;

endmodule // utm_uptime_maps
